//--- src/vector_map_pkg.sv
// constants shared by the interrupt vector and priority map
package vector_map_pkg;

    localparam int          NUM_PRIO          = 30;
    localparam int          PRIO_W            = 5;

    // vector addresses
    localparam logic [15:0] VEC_RESET         = 16'h8000;
    localparam logic [15:0] VEC_TRAP          = 16'h8004;
    localparam logic [15:0] VEC_NMI           = 16'h8008;
    localparam logic [15:0] VEC_STEP          = 16'h0004;
    localparam logic [15:0] VEC_LAST          = 16'h807c;
    localparam logic [15:0] VEC_UART_RX       = 16'h8050;

    // priority positions of the sources
    localparam logic [4:0]  PRIO_NMI          = 5'h00;
    localparam logic [4:0]  PRIO_WAKEUP       = 5'h01;
    localparam logic [4:0]  PRIO_CLK          = 5'h02;
    localparam logic [4:0]  PRIO_PORT0        = 5'h03;
    localparam logic [4:0]  PRIO_AUX_TIM      = 5'h04;
    localparam logic [4:0]  PRIO_FAST_IN      = 5'h05;
    localparam logic [4:0]  PRIO_PWM0         = 5'h06;
    localparam logic [4:0]  PRIO_PWM1         = 5'h07;
    localparam logic [4:0]  PRIO_PWM2         = 5'h0f;
    localparam logic [4:0]  PRIO_PWM3         = 5'h10;
    localparam logic [4:0]  PRIO_UART_TX      = 5'h11;
    localparam logic [4:0]  PRIO_UART_RX      = 5'h12;
    localparam logic [4:0]  PRIO_I2C          = 5'h13;
    localparam logic [4:0]  PRIO_ADC          = 5'h16;
    localparam logic [4:0]  PRIO_SYS_TIM      = 5'h17;
    localparam logic [4:0]  PRIO_FLASH        = 5'h18;
    localparam logic [4:0]  PRIO_DALI         = 5'h19;
    localparam logic [4:0]  PRIO_PWM4         = 5'h1a;
    localparam logic [4:0]  PRIO_PWM5         = 5'h1b;

    // reserved slots 8..14, 20, 21, 28, 29
    localparam logic [29:0] RESERVED_MASK     = 30'h3030_7f00;
    // direct wake sources: halt 0,3,5; active-halt 0,1,3,5,19
    localparam logic [29:0] HALT_WAKE_MASK    = 30'h0000_0029;
    localparam logic [29:0] AHALT_WAKE_MASK   = 30'h0008_002b;

    typedef enum logic [2:0] {
        ST_BOOT    = 3'b001,
        ST_IDLE    = 3'b010,
        ST_PRESENT = 3'b100
    } map_state_t;

    // vector slot of a priority number
    function automatic logic [15:0] prio_vector(input logic [4:0] prio);
        prio_vector = VEC_NMI + VEC_STEP * {11'h000, prio};
    endfunction

endpackage

//--- src/lowest_index_picker.sv
// picks the lowest set bit of the pending vector
`timescale 1ns/1ps
`default_nettype none
module lowest_index_picker
    import vector_map_pkg::*;
(
    input  wire logic [29:0] req,
    output logic             found,
    output logic [4:0]       idx
);

    // scan from the top so the lowest number wins last
    always_comb begin
        found = 1'b0;
        idx   = 5'h00;
        for (int i = NUM_PRIO - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = 5'(i);
            end
        end
    end

endmodule
`default_nettype wire

//--- src/interrupt_vector_priority_map.sv
// interrupt source to priority and vector map with wake flags
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - reset at 8000h, trap 8004h, NMI 8008h, priorities 1..29 in 4-byte slots
// R2 - NMI is priority 0 at 8008h and wakes from halt and active-halt
// R3 - reserved priorities 8-14, 20, 21, 28, 29 never raise a request
// R4 - UART receive full uses priority 18 at 8050h, no direct wake
// R5 - each port-0 pin can be set to raise an NMI request
// R6 - each port-0 pin can be set to raise a maskable request
// R7 - among pending maskable requests the lowest priority number goes first
module interrupt_vector_priority_map
    import vector_map_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        core_trap,
    input  wire logic        core_vector_ack,
    input  wire logic        nmi_request,
    input  wire logic        auto_wakeup_source,
    input  wire logic        clock_controller_source,
    input  wire logic [5:0]  port_zero_external_lines,
    input  wire logic [5:0]  port_zero_nmi_enable,
    input  wire logic [5:0]  port_zero_irq_enable,
    input  wire logic        auxiliary_timer_source,
    input  wire logic [5:0]  fast_input_external_lines,
    input  wire logic [5:0]  pwm_state_machine_unit,
    input  wire logic        uart_tx_complete,
    input  wire logic        uart_rx_full,
    input  wire logic        i2c_source,
    input  wire logic        adc_end_of_conversion,
    input  wire logic        system_timer_source,
    input  wire logic        end_of_programming,
    input  wire logic        write_protected_page_attempt,
    input  wire logic        dali_source,
    output logic             vector_valid,
    output logic [15:0]      vector_addr,
    output logic             vector_is_nmi,
    output logic             wake_halt,
    output logic             wake_active_halt
);

    map_state_t  state_r;
    map_state_t  state_nxt;
    logic [29:0] pend_r;
    logic [29:0] pend_nxt;
    logic [29:0] set_req;
    logic [29:0] clr_req;
    logic        trap_pend_r;
    logic        trap_pend_nxt;
    logic        sel_trap_r;
    logic        sel_trap_nxt;
    logic [4:0]  sel_r;
    logic [4:0]  sel_nxt;
    logic [15:0] vector_nxt;
    logic        is_nmi_nxt;
    logic        wake_halt_nxt;
    logic        wake_ahalt_nxt;
    logic        pick_found;
    logic [4:0]  pick_idx;
    logic        port_nmi_hit;
    logic        port_irq_hit;

    // port-0 pins steered by separate enables to the NMI, to their maskable slot, to both or to neither
    // R5 port nmi path
    assign port_nmi_hit = |(port_zero_external_lines & port_zero_nmi_enable);
    // R6 port irq path
    assign port_irq_hit = |(port_zero_external_lines & port_zero_irq_enable);

    // request vector indexed by priority; reserved slots stay zero
    always_comb begin
        set_req               = 30'h0000_0000;
        // R2 nmi at zero
        set_req[PRIO_NMI]     = nmi_request | port_nmi_hit;
        set_req[PRIO_WAKEUP]  = auto_wakeup_source;
        set_req[PRIO_CLK]     = clock_controller_source;
        set_req[PRIO_PORT0]   = port_irq_hit;
        set_req[PRIO_AUX_TIM] = auxiliary_timer_source;
        set_req[PRIO_FAST_IN] = |fast_input_external_lines;
        set_req[PRIO_PWM0]    = pwm_state_machine_unit[0];
        set_req[PRIO_PWM1]    = pwm_state_machine_unit[1];
        set_req[PRIO_PWM2]    = pwm_state_machine_unit[2];
        set_req[PRIO_PWM3]    = pwm_state_machine_unit[3];
        set_req[PRIO_UART_TX] = uart_tx_complete;
        // R4 uart receive slot
        set_req[PRIO_UART_RX] = uart_rx_full;
        set_req[PRIO_I2C]     = i2c_source;
        set_req[PRIO_ADC]     = adc_end_of_conversion;
        set_req[PRIO_SYS_TIM] = system_timer_source;
        set_req[PRIO_FLASH]   = end_of_programming | write_protected_page_attempt;
        set_req[PRIO_DALI]    = dali_source;
        set_req[PRIO_PWM4]    = pwm_state_machine_unit[4];
        set_req[PRIO_PWM5]    = pwm_state_machine_unit[5];
        // R3 reserved slots blocked
        set_req               = set_req & ~RESERVED_MASK;
    end

    // R7 lowest number wins
    lowest_index_picker u_picker (
        .req   (pend_r),
        .found (pick_found),
        .idx   (pick_idx)
    );

    // pending flags: a new request in the ack cycle survives the clear
    always_comb begin
        clr_req = 30'h0000_0000;
        if (state_r == ST_PRESENT && core_vector_ack && !sel_trap_r) begin
            clr_req[sel_r] = 1'b1;
        end
        pend_nxt      = (pend_r & ~clr_req) | set_req;
        trap_pend_nxt = (trap_pend_r & ~(state_r == ST_PRESENT && core_vector_ack && sel_trap_r)) | core_trap;
        // wake is taken from direct sources only; indirect ones come via port 0
        wake_halt_nxt  = |(pend_nxt & HALT_WAKE_MASK);
        wake_ahalt_nxt = |(pend_nxt & AHALT_WAKE_MASK);
    end

    // presentation sequence: reset vector first, then trap, then priorities
    always_comb begin
        state_nxt    = state_r;
        sel_nxt      = sel_r;
        sel_trap_nxt = sel_trap_r;
        vector_nxt   = vector_addr;
        is_nmi_nxt   = vector_is_nmi;
        case (state_r)
            ST_BOOT: begin
                if (core_vector_ack) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // R1 trap ahead of nmi
                if (trap_pend_r) begin
                    state_nxt    = ST_PRESENT;
                    sel_trap_nxt = 1'b1;
                    vector_nxt   = VEC_TRAP;
                    is_nmi_nxt   = 1'b0;
                end else if (pick_found) begin
                    // R1 slot from priority
                    state_nxt    = ST_PRESENT;
                    sel_trap_nxt = 1'b0;
                    sel_nxt      = pick_idx;
                    vector_nxt   = prio_vector(pick_idx);
                    is_nmi_nxt   = (pick_idx == PRIO_NMI);
                end
            end
            ST_PRESENT: begin
                // vector held stable until the core takes it
                if (core_vector_ack) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r          <= ST_BOOT;
            pend_r           <= 30'h0000_0000;
            trap_pend_r      <= 1'b0;
            sel_trap_r       <= 1'b0;
            sel_r            <= 5'h00;
            vector_addr      <= VEC_RESET;
            vector_is_nmi    <= 1'b0;
            wake_halt        <= 1'b0;
            wake_active_halt <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            pend_r           <= pend_nxt;
            trap_pend_r      <= trap_pend_nxt;
            sel_trap_r       <= sel_trap_nxt;
            sel_r            <= sel_nxt;
            vector_addr      <= vector_nxt;
            vector_is_nmi    <= is_nmi_nxt;
            wake_halt        <= wake_halt_nxt;
            wake_active_halt <= wake_ahalt_nxt;
        end
    end

    // handshake out is combinational
    assign vector_valid = (state_r != ST_IDLE);

    // R1 reset vector check
    a_reset_vector_first: assert property (@(posedge clk) disable iff (reset) // R1
        state_r == ST_BOOT |-> vector_valid && vector_addr == VEC_RESET)
        else $error("reset vector not presented at boot");

    // R1 slot range check
    a_vector_slot_range: assert property (@(posedge clk) disable iff (reset) // R1
        (state_r == ST_PRESENT && !sel_trap_r) |->
            vector_addr == VEC_NMI + VEC_STEP * {11'h000, sel_r} && vector_addr <= VEC_LAST)
        else $error("vector outside its priority slot");

    // R2 nmi vector and wake
    a_nmi_vector_wake: assert property (@(posedge clk) disable iff (reset) // R2
        (state_r == ST_IDLE && pend_r[0] && !trap_pend_r) |=>
            vector_addr == VEC_NMI && vector_is_nmi && wake_halt && wake_active_halt)
        else $error("nmi not presented at its vector or without wake");

    // R3 reserved never pending
    a_reserved_quiet: assert property (@(posedge clk) disable iff (reset) // R3
        (pend_r & RESERVED_MASK) == 30'h0000_0000)
        else $error("reserved slot raised a request");

    // R4 uart receive vector and no direct wake
    a_uart_rx_slot: assert property (@(posedge clk) disable iff (reset) // R4
        (pend_r == (30'h0000_0001 << PRIO_UART_RX) && set_req == 30'h0000_0000 && state_r == ST_IDLE
            && !trap_pend_r) |=>
            vector_addr == VEC_UART_RX && !wake_halt && !wake_active_halt)
        else $error("uart receive mapped wrongly or woke directly");

    // R5 port pin to nmi
    a_port_nmi_route: assert property (@(posedge clk) disable iff (reset) // R5
        port_nmi_hit |=> pend_r[0] ##0 wake_halt)
        else $error("port pin did not raise nmi");

    // R6 port pin to maskable slot
    a_port_irq_route: assert property (@(posedge clk) disable iff (reset) // R6
        port_irq_hit |=> pend_r[3] && wake_halt)
        else $error("port pin did not raise its request");

    // R7 nothing lower was pending when a slot was chosen
    a_lowest_first: assert property (@(posedge clk) disable iff (reset) // R7
        (state_r == ST_IDLE && !trap_pend_r && pick_found) |=>
            ($past(pend_r) & ((30'h0000_0001 << sel_r) - 30'h0000_0001)) == 30'h0000_0000)
        else $error("a lower priority number was skipped");

endmodule
`default_nettype wire

//--- verif/core_fetch_model.sv
// core model that takes presented interrupt vectors
`timescale 1ns/1ps
`default_nettype none
module core_fetch_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        vector_valid,
    input  wire logic [15:0] vector_addr,
    input  wire logic        vector_is_nmi,
    input  wire logic [3:0]  ack_delay,
    output var logic         core_vector_ack,
    output logic [15:0]      taken_addr,
    output logic             taken_nmi,
    output int               taken_count
);
    int wait_cnt;

    // ack rises after a falling edge and holds until a rising edge samples it
    always @(negedge clk) begin
        if (reset || core_vector_ack) begin
            core_vector_ack <= 1'b0;
            wait_cnt <= 0;
        end else if (vector_valid === 1'b1) begin
            if (wait_cnt >= ack_delay)
                core_vector_ack <= 1'b1;
            else
                wait_cnt <= wait_cnt + 1;
        end
    end

    // vector is taken at the edge that samples the ack
    always @(posedge clk) begin
        if (reset) begin
            taken_count <= 0;
        end else if (core_vector_ack && vector_valid) begin
            taken_addr <= vector_addr;
            taken_nmi <= vector_is_nmi;
            taken_count <= taken_count + 1;
        end
    end
endmodule
`default_nettype wire

//--- verif/test_interrupt_vector_priority_map.sv
// self-checking bench for the vector and priority map
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_vector_priority_map;
    import vector_map_pkg::*;
    logic        clk, reset, trap, ack, v_valid, v_nmi, w_halt, w_ahalt, t_nmi;
    logic [29:0] raise;
    logic [5:0]  p0, p0_nmi, p0_irq;
    logic [15:0] v_addr, t_addr;
    logic [3:0]  dly;
    int          t_cnt, seen, fail_count, total_checks;

    // raise bit n drives the source of priority n, except bit 3 (port 0 is driven by p0); bit 28 drives the second flash cause
    interrupt_vector_priority_map dut_u (
        .clk(clk), .reset(reset), .core_trap(trap), .core_vector_ack(ack), .nmi_request(raise[0]),
        .auto_wakeup_source(raise[1]), .clock_controller_source(raise[2]), .port_zero_external_lines(p0),
        .port_zero_nmi_enable(p0_nmi), .port_zero_irq_enable(p0_irq), .auxiliary_timer_source(raise[4]),
        .fast_input_external_lines({raise[5], 5'h00}),
        .pwm_state_machine_unit({raise[27], raise[26], raise[16], raise[15], raise[7], raise[6]}),
        .uart_tx_complete(raise[17]), .uart_rx_full(raise[18]), .i2c_source(raise[19]),
        .adc_end_of_conversion(raise[22]), .system_timer_source(raise[23]), .end_of_programming(raise[24]),
        .write_protected_page_attempt(raise[28]), .dali_source(raise[25]), .vector_valid(v_valid),
        .vector_addr(v_addr), .vector_is_nmi(v_nmi), .wake_halt(w_halt), .wake_active_halt(w_ahalt));

    core_fetch_model core_u (.clk(clk), .reset(reset), .vector_valid(v_valid), .vector_addr(v_addr),
        .vector_is_nmi(v_nmi), .ack_delay(dly), .core_vector_ack(ack), .taken_addr(t_addr),
        .taken_nmi(t_nmi), .taken_count(t_cnt));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // bounded wait for the core to take one vector, then compare it
    task automatic take(input logic [15:0] exp_a, input logic exp_n);
        for (int i = 0; i < 60 && t_cnt == seen; i++)
            @(negedge clk);
        if (t_cnt == seen) begin
            check16(16'(t_cnt), 16'(seen + 1));
            tally_and_finish();
        end else begin
            seen = t_cnt;
            check16(t_addr, exp_a);
            check16({15'h0000, t_nmi}, {15'h0000, exp_n});
        end
    endtask

    // one-cycle request pulse; the design holds it as pending
    task automatic pulse(input logic [29:0] bits, input logic tr);
        @(negedge clk);
        raise = bits;
        trap = tr;
        @(negedge clk);
        raise = 30'h0000_0000;
        trap = 1'b0;
    endtask

    task automatic t_boot();
        take(VEC_RESET, 1'b0);
        pulse(30'h0000_0000, 1'b1);
        take(16'h8004, 1'b0);
        $display("test boot_and_trap done");
    endtask

    // every source but port 0 alone, reserved slots skipped, slow core so flags can settle
    task automatic t_each();
        int q;
        dly = 4'h3;
        for (int p = 0; p < 29; p++) begin
            if (p == 3 || (p > 7 && p < 15) || p == 20 || p == 21)
                continue;
            q = (p == 28) ? 24 : p;
            pulse(30'h1 << p, 1'b0);
            for (int i = 0; i < 10 && v_valid !== 1'b1; i++)
                @(negedge clk);
            check16({15'h0000, v_valid}, 16'h0001);
            @(negedge clk);
            check16({w_halt, w_ahalt}, {p == 0 || p == 5, p == 0 || p == 1 || p == 5 || p == 19});
            take(16'h8008 + 16'(4 * q), p == 0);
        end
        $display("test each_source done");
    endtask

    // pin 5 routed to the nmi, pin 0 to the maskable line; then all pins routed nowhere
    task automatic t_port();
        p0_nmi = 6'h20;
        p0_irq = 6'h01;
        @(negedge clk);
        p0 = 6'h21;
        @(negedge clk);
        p0 = 6'h00;
        take(VEC_NMI, 1'b1);
        take(16'h8014, 1'b0);
        p0_nmi = 6'h00;
        p0_irq = 6'h00;
        p0 = 6'h3f;
        repeat (2) @(negedge clk);
        p0 = 6'h00;
        repeat (12) @(negedge clk);
        check16(16'(t_cnt), 16'(seen));
        $display("test port_zero done");
    endtask

    // trap, nmi and three maskable sources at once, prompt core
    task automatic t_order();
        dly = 4'h0;
        pulse(30'h0804_0011, 1'b1);
        take(16'h8004, 1'b0);
        take(VEC_NMI, 1'b1);
        take(16'h8018, 1'b0);
        take(VEC_UART_RX, 1'b0);
        take(16'h8074, 1'b0);
        $display("test priority_order done");
    endtask

    initial begin
        reset = 1'b1;
        trap = 1'b0;
        raise = 30'h0000_0000;
        p0 = 6'h00;
        p0_nmi = 6'h00;
        p0_irq = 6'h00;
        dly = 4'h1;
        seen = 0;
        fail_count = 0;
        total_checks = 0;
        repeat (2) @(negedge clk);
        check16(v_addr, VEC_RESET);
        check16({15'h0000, v_valid}, 16'h0001);
        reset = 1'b0;
        t_boot();
        t_each();
        t_port();
        t_order();
        tally_and_finish();
    end
endmodule
`default_nettype wire
